// ===== common/rcpd_pkg.sv
// Purpose: Shared constants and types for the reset-cause and power-down block
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes:   Every offset, field position and reset value is named here

package rcpd_pkg;

  // ==========================================================================
  // Bus shape
  localparam int          ADDR_W      = 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0]  OFS_FLAGS   = 8'h00;
  localparam logic [7:0]  OFS_ARM     = 8'h04;
  localparam logic [7:0]  OFS_CLKSEL  = 8'h08;
  localparam logic [7:0]  OFS_CFG     = 8'h0c;
  localparam logic [7:0]  OFS_STATUS  = 8'h10;

  // ==========================================================================
  // Reset-cause flag fields
  localparam int          FLG_PIN     = 4;
  localparam int          FLG_WDT     = 2;
  localparam int          FLG_LVR     = 1;
  localparam logic [7:0]  FLG_MASK    = 8'h16;
  localparam logic [7:0]  FLG_LVR_RST = 8'h02;

  // ==========================================================================
  // Stop arming, clock select, configuration
  localparam logic [7:0]  ARM_PATTERN = 8'ha5;
  localparam logic [7:0]  ARM_RST     = 8'h00;
  localparam int          CLK_LO      = 3;
  localparam int          CLK_HI      = 4;
  localparam logic [1:0]  CLK_SLOW    = 2'h0;
  localparam int          CFG_RING    = 0;
  localparam int          CFG_STAB_LO = 8;
  localparam int          CFG_STAB_HI = 15;
  localparam logic [7:0]  STAB_RST    = 8'h10;
  localparam logic [7:0]  OP_IDLE     = 8'h6f;
  localparam logic [7:0]  OP_STOP     = 8'h7f;
  localparam logic [15:0] RESET_VEC   = 16'h0100;

  // ==========================================================================
  // Power state, one-hot
  typedef enum logic [3:0] {
    ST_RUN  = 4'h1,
    ST_IDLE = 4'h2,
    ST_STOP = 4'h4,
    ST_STAB = 4'h8
  } rcpd_state_t;

  // Reset sources seen by the block
  typedef struct packed {
    logic pin;
    logic wdt;
  } rcpd_src_t;

  // Control toward the CPU, clock tree and oscillators
  typedef struct packed {
    logic        cpu_clk_en;
    logic        periph_clk_en;
    logic        main_osc_en;
    logic        ring_osc_en;
    logic        port_dir_hold;
    logic [1:0]  clk_sel;
    logic        fetch_load;
    logic [15:0] fetch_addr;
    logic        wake_irq;
  } rcpd_pm_t;

endpackage : rcpd_pkg

// ===== design/rcpd_top.sv
// Purpose: Reset-cause flags and stop/idle power-down sequencing
// Assumes: CPU core reports decoded opcodes; inputs synchronous to clk
// Notes:   lvr_rst is the only reset that clears the pin and watchdog flags

`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Pin and low-voltage flags record reset source
// - Writing 0 clears a flag; 1 ignored
// - Pin/watchdog reset sets flags of active sources
// - Pin, watchdog flags survive non-low-voltage resets
// - Stop entered only after arming then stop
// - Stop halts CPU, peripherals, main oscillator
// - Ring oscillator in stop is configurable
// - Reset or interrupt exits stop; arm self-clears
// - Reset exit restores controls, clock select slow
// - After stabilization, fetch starts at 0100h
// - Interrupt exit keeps control registers except arm, which clears
// - Interrupt exit uses programmed stabilization setting
// - Interrupt exit keeps clock select unchanged
// - Waking interrupt serviced, then resume next instruction
// - Any enabled interrupt releases stop likewise
// - Idle entered on opcode 6Fh
// - Idle gates CPU clock, peripherals keep running
// - Port directions held on idle entry
// - Reset exit from idle restores slow clock
// - Enabled interrupt ends idle, clock select kept
// - Masked interrupts never wake idle
module rcpd_top (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       lvr_rst,
  input  wire rcpd_pkg::rcpd_src_t        rst_src,
  input  wire logic                       cpu_op_valid,
  input  wire logic [7:0]                 cpu_opcode,
  input  wire logic                       irq_req,
  input  wire logic                       irq_unmasked,
  output var  rcpd_pkg::rcpd_pm_t         pm,
  input  wire logic [rcpd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [rcpd_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);

  // ==========================================================================
  // Reset tree
  // Low-voltage reset is the power-on class reset, so it also resets everything
  wire sys_rst = rst | lvr_rst;

  // ==========================================================================
  // Write channel capture
  logic                      aw_held_r;
  logic [rcpd_pkg::ADDR_W-1:0] aw_addr_r;
  logic                      w_held_r;
  logic [31:0]               w_data_r;
  logic [3:0]                w_strb_r;
  logic                      bvalid_r;
  logic [1:0]                bresp_r;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_held_r & w_held_r & ~bvalid_r;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_held_r <= 1'b0;
      if (w_take)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Write decode
  wire [5:0] wr_word   = aw_addr_r[rcpd_pkg::ADDR_W-1:2];
  wire       wr_lane0  = w_strb_r[0];
  wire       hit_flags = wr_word == rcpd_pkg::OFS_FLAGS[7:2];
  wire       hit_arm   = wr_word == rcpd_pkg::OFS_ARM[7:2];
  wire       hit_clk   = wr_word == rcpd_pkg::OFS_CLKSEL[7:2];
  wire       hit_cfg   = wr_word == rcpd_pkg::OFS_CFG[7:2];
  wire       hit_stat  = wr_word == rcpd_pkg::OFS_STATUS[7:2];
  wire       wr_map    = hit_flags | hit_arm | hit_clk | hit_cfg | hit_stat;
  wire       we_flags  = wr_go & hit_flags & wr_lane0;
  wire       we_arm    = wr_go & hit_arm & wr_lane0;
  wire       we_clk    = wr_go & hit_clk & wr_lane0;
  wire       we_ring   = wr_go & hit_cfg & wr_lane0;
  wire       we_stab   = wr_go & hit_cfg & w_strb_r[1];

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= rcpd_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_map ? rcpd_pkg::RESP_OKAY : rcpd_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  assign s_axi_awready = ~aw_held_r;
  assign s_axi_wready  = ~w_held_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  // ==========================================================================
  // Reset-cause flags
  // Held only by lvr_rst; a pin or watchdog reset leaves the flop running
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  wire  [7:0] flag_set  = rst ? {3'h0, rst_src.pin, 1'b0, rst_src.wdt, 2'h0}
                              : 8'h00;
  wire  [7:0] flag_keep = we_flags ? (flags_r & w_data_r[7:0]) : flags_r;

  // Set beats a simultaneous clear
  assign flags_nxt = (flag_keep | flag_set) & rcpd_pkg::FLG_MASK;

  always_ff @(posedge clk or posedge lvr_rst)
  begin
    if (lvr_rst)
      flags_r <= rcpd_pkg::FLG_LVR_RST;
    else
      flags_r <= flags_nxt;
  end

  // ==========================================================================
  // Control registers, all loaded by any reset; arm, clock select, ring cleared, stab_r to STAB_RST
  logic [7:0] arm_r;
  logic [1:0] clksel_r;
  logic       ring_keep_r;
  logic [7:0] stab_r;
  logic [7:0] arm_nxt;

  rcpd_pkg::rcpd_state_t state_r;
  rcpd_pkg::rcpd_state_t state_nxt;
  logic [7:0]            stab_cnt_r;
  logic                  exit_irq_r;

  wire irq_any   = irq_req & irq_unmasked;
  wire in_run    = state_r == rcpd_pkg::ST_RUN;
  wire in_idle   = state_r == rcpd_pkg::ST_IDLE;
  wire in_stop   = state_r == rcpd_pkg::ST_STOP;
  wire in_stab   = state_r == rcpd_pkg::ST_STAB;
  wire armed     = arm_r == rcpd_pkg::ARM_PATTERN;
  wire op_idle   = in_run & cpu_op_valid & (cpu_opcode == rcpd_pkg::OP_IDLE);
  wire op_stop   = in_run & cpu_op_valid & (cpu_opcode == rcpd_pkg::OP_STOP);
  wire go_stop   = op_stop & armed;
  wire stop_wake = in_stop & irq_any;
  wire idle_wake = in_idle & irq_any;
  wire stab_done = in_stab & (stab_cnt_r == stab_r);

  // Arm clears itself on any stop exit; reset exit is covered by sys_rst
  assign arm_nxt = stop_wake ? rcpd_pkg::ARM_RST
                 : (we_arm ? w_data_r[7:0] : arm_r);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      arm_r       <= rcpd_pkg::ARM_RST;
      clksel_r    <= rcpd_pkg::CLK_SLOW;
      ring_keep_r <= 1'b0;
      stab_r      <= rcpd_pkg::STAB_RST;
    end
    else
    begin
      arm_r <= arm_nxt;
      // Interrupt exits never touch these
      if (we_clk)
        clksel_r <= w_data_r[rcpd_pkg::CLK_HI:rcpd_pkg::CLK_LO];
      if (we_ring)
        ring_keep_r <= w_data_r[rcpd_pkg::CFG_RING];
      if (we_stab)
        stab_r <= w_data_r[rcpd_pkg::CFG_STAB_HI:rcpd_pkg::CFG_STAB_LO];
    end
  end

  // ==========================================================================
  // Power state machine
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      rcpd_pkg::ST_RUN:
      begin
        if (go_stop)
          state_nxt = rcpd_pkg::ST_STOP;
        else if (op_idle)
          state_nxt = rcpd_pkg::ST_IDLE;
      end
      rcpd_pkg::ST_IDLE:
      begin
        // Oscillator never stopped, so no stabilization wait
        if (idle_wake)
          state_nxt = rcpd_pkg::ST_RUN;
      end
      rcpd_pkg::ST_STOP:
      begin
        if (stop_wake)
          state_nxt = rcpd_pkg::ST_STAB;
      end
      rcpd_pkg::ST_STAB:
      begin
        if (stab_done)
          state_nxt = rcpd_pkg::ST_RUN;
      end
      default:
        state_nxt = rcpd_pkg::ST_RUN;
    endcase
  end

  // Reset lands in stabilization, so every reset exit waits before fetching
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r    <= rcpd_pkg::ST_STAB;
      stab_cnt_r <= 8'h00;
      exit_irq_r <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      stab_cnt_r <= in_stab ? stab_cnt_r + 8'h01 : 8'h00;
      if (stop_wake)
        exit_irq_r <= 1'b1;
      else if (stab_done)
        exit_irq_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Outputs, all registered
  rcpd_pkg::rcpd_pm_t pm_nxt;

  wire sleeping = (state_nxt == rcpd_pkg::ST_STOP) | (state_nxt == rcpd_pkg::ST_IDLE);
  wire stopped  = state_nxt == rcpd_pkg::ST_STOP;

  always_comb
  begin
    pm_nxt               = '0;
    pm_nxt.cpu_clk_en    = ~sleeping & (state_nxt != rcpd_pkg::ST_STAB);
    pm_nxt.periph_clk_en = ~stopped;
    pm_nxt.main_osc_en   = ~stopped;
    pm_nxt.ring_osc_en   = ~stopped | ring_keep_r;
    pm_nxt.port_dir_hold = state_nxt == rcpd_pkg::ST_IDLE;
    pm_nxt.clk_sel       = we_clk ? w_data_r[rcpd_pkg::CLK_HI:rcpd_pkg::CLK_LO]
                                  : clksel_r;
    pm_nxt.fetch_load    = stab_done & ~exit_irq_r;
    pm_nxt.fetch_addr    = rcpd_pkg::RESET_VEC;
    pm_nxt.wake_irq      = idle_wake | (stab_done & exit_irq_r);
  end

  // Reset value holds the CPU halted while the oscillator settles
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pm               <= '0;
      pm.periph_clk_en <= 1'b1;
      pm.main_osc_en   <= 1'b1;
      pm.ring_osc_en   <= 1'b1;
      pm.fetch_addr    <= rcpd_pkg::RESET_VEC;
    end
    else
      pm <= pm_nxt;
  end

  // ==========================================================================
  // Read channel
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire [5:0]  rd_word = s_axi_araddr[rcpd_pkg::ADDR_W-1:2];
  wire        rd_f    = rd_word == rcpd_pkg::OFS_FLAGS[7:2];
  wire        rd_a    = rd_word == rcpd_pkg::OFS_ARM[7:2];
  wire        rd_c    = rd_word == rcpd_pkg::OFS_CLKSEL[7:2];
  wire        rd_g    = rd_word == rcpd_pkg::OFS_CFG[7:2];
  wire        rd_s    = rd_word == rcpd_pkg::OFS_STATUS[7:2];
  wire        rd_map  = rd_f | rd_a | rd_c | rd_g | rd_s;
  wire [31:0] rd_val  = rd_f ? {24'h0, flags_r}
                      : rd_a ? {24'h0, arm_r}
                      : rd_c ? {27'h0, clksel_r, 3'h0}
                      : rd_g ? {16'h0, stab_r, 7'h0, ring_keep_r}
                      : rd_s ? {28'h0, state_r}
                      : 32'h0000_0000;
  wire        ar_take = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= rcpd_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_map ? rcpd_pkg::RESP_OKAY : rcpd_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  lvr_flags_a: assert property (@(posedge clk) $fell(lvr_rst) |->
    flags_r == rcpd_pkg::FLG_LVR_RST)
    else $error("flags wrong after low-voltage reset");

  pin_flag_set_a: assert property (@(posedge clk) disable iff (lvr_rst)
    rst && rst_src.pin |=> flags_r[rcpd_pkg::FLG_PIN])
    else $error("pin flag not set by pin reset");

  wdt_flag_set_a: assert property (@(posedge clk) disable iff (lvr_rst)
    rst && rst_src.wdt |=> flags_r[rcpd_pkg::FLG_WDT])
    else $error("watchdog flag not set");

  flag_keep_a: assert property (@(posedge clk) disable iff (lvr_rst)
    !rst && we_flags && w_data_r[rcpd_pkg::FLG_WDT] && flags_r[rcpd_pkg::FLG_WDT]
    |=> flags_r[rcpd_pkg::FLG_WDT])
    else $error("writing one altered a flag");

  stop_needs_arm_a: assert property ($rose(in_stop) |->
    $past(armed) && $past(cpu_opcode) == rcpd_pkg::OP_STOP)
    else $error("stop entered without arming");

  stop_halts_a: assert property (in_stop |=>
    !pm.cpu_clk_en && !pm.periph_clk_en && !pm.main_osc_en ||
    !in_stop)
    else $error("clocks running in stop");

  arm_clear_a: assert property (stop_wake |=> arm_r == rcpd_pkg::ARM_RST)
    else $error("arm not cleared on stop exit");

  stab_len_a: assert property (stop_wake && stab_r == 8'h02 |=>
    in_stab [*3] ##1 in_run)
    else $error("stabilization length wrong");

  idle_gate_a: assert property (op_idle |=>
    !pm.cpu_clk_en && pm.periph_clk_en && pm.port_dir_hold)
    else $error("idle gating wrong");

  idle_masked_a: assert property (in_idle && !irq_unmasked |=> in_idle)
    else $error("masked interrupt woke idle");

  clk_keep_a: assert property (idle_wake && !we_clk |=>
    $stable(clksel_r) && pm.wake_irq)
    else $error("clock select changed on interrupt exit");

  fetch_vec_a: assert property (pm.fetch_load |->
    pm.fetch_addr == rcpd_pkg::RESET_VEC && !$past(exit_irq_r))
    else $error("fetch after interrupt exit or bad vector");

  cover_stop_irq: cover property (stop_wake ##[1:300] pm.wake_irq);
  cover_idle_irq: cover property (op_idle ##[1:50] idle_wake);
  cover_reset_fetch: cover property (pm.fetch_load);

endmodule : rcpd_top

`default_nettype wire

// ===== sim/rcpd_cpu_model.sv
// Purpose: Behavioural CPU core that issues the power-down opcodes
// Assumes: A core retires instructions only while its clock is enabled
// Notes:   Once released, the opcode lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module rcpd_cpu_model (
  input  wire logic               clk,
  input  wire rcpd_pkg::rcpd_pm_t pm,
  output logic                    op_valid,
  output logic [7:0]              opcode
);
  // ==========================================================================
  // Instruction issue
  initial
  begin
    op_valid = 1'b0;
    opcode   = 8'h00;
  end

  task automatic exec(input logic [7:0] op, output bit late);
    int n;
    @(posedge clk);
    // A gated core retires nothing, so hold off until its clock runs
    for (n = 0; n < 100 && pm.cpu_clk_en !== 1'b1; n++)
      @(posedge clk);
    late = (n == 100);
    op_valid <= 1'b1; // Sleep opcodes issued whole, one cycle each
    opcode   <= op;
    @(posedge clk);
    op_valid <= 1'b0;
    opcode   <= ~op;
  endtask : exec
endmodule : rcpd_cpu_model
`default_nettype wire

// ===== sim/reset_cause_and_power_down_tb.sv
// Purpose: Self-checking bench for reset-cause flags and power-down modes
// Assumes: AXI4-Lite master in this bench, CPU model drives the opcodes
// Notes:   Stabilization lengths are compared by difference, not absolute
`timescale 1ns/100ps
`default_nettype none
module reset_cause_and_power_down_tb;
  // ==========================================================================
  // Signals
  logic                clk     = 1'b0;
  logic                rst     = 1'b1;
  logic                lvr_rst = 1'b1;
  logic                irq_req = 1'b0;
  logic                irq_unm = 1'b0;
  rcpd_pkg::rcpd_src_t src     = '0;
  rcpd_pkg::rcpd_pm_t  pm;
  logic                op_valid;
  logic [7:0]          opcode;
  logic [7:0]          awaddr  = 8'h00;
  logic [7:0]          araddr  = 8'h00;
  logic [31:0]         wdata   = 32'h0;
  logic                awvalid = 1'b0;
  logic                wvalid  = 1'b0;
  logic                bready  = 1'b0;
  logic                arvalid = 1'b0;
  logic                rready  = 1'b0;
  logic [3:0]          wstrb   = 4'hf;
  bit                  to;
  logic                awready, wready, bvalid, arready, rvalid;
  logic [1:0]          bresp, rresp, r;
  logic [31:0]         rdata, d;
  logic [7:0]          fl;
  logic                p, w;
  int                  errors  = 0;
  int                  checks  = 0;
  int                  i, k;
  int                  n[2];

  always #2 clk = ~clk;

  rcpd_cpu_model cpu_u (.clk(clk), .pm(pm), .op_valid(op_valid), .opcode(opcode));

  rcpd_top dut_u (.clk(clk), .rst(rst), .lvr_rst(lvr_rst), .rst_src(src),
    .cpu_op_valid(op_valid), .cpu_opcode(opcode), .irq_req(irq_req),
    .irq_unmasked(irq_unm), .pm(pm), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ==========================================================================
  // Expectations and reporting
  function automatic logic [7:0] rexp(input logic [7:0] o, input logic pp,
                                      input logic ww, input logic lv);
    return lv ? 8'h02 : (o | {3'h0, pp, 1'b0, ww, 2'h0});
  endfunction : rexp

  function automatic logic [7:0] wexp(input logic [7:0] o, input logic [31:0] v);
    return o & v[7:0] & rcpd_pkg::FLG_MASK;
  endfunction : wexp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic hang();
    errors++;
    $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    finish_test();
  endtask : hang

  // ==========================================================================
  // Bus, reset and sleep helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int j;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (j = 0; j < 50; j++)
    begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (j == 50) hang();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int j;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (j = 0; j < 50; j++)
    begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    v  = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (j == 50) hang();
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(rcpd_pkg::RESP_OKAY));
  endtask : rchk

  // Waits for the wake pulse or, when wake is 0, the fetch pulse
  task automatic wpulse(input bit wake, output int c);
    for (c = 0; c < 200; c++)
    begin
      @(posedge clk);
      #1;
      if ((wake ? pm.wake_irq : pm.fetch_load) === 1'b1) return;
    end
    hang();
  endtask : wpulse

  task automatic do_rst(input logic pp, input logic ww, input logic lv);
    int c;
    @(posedge clk);
    src     <= '{pin: pp, wdt: ww};
    rst     <= ~lv;
    lvr_rst <= lv;
    repeat (3) @(posedge clk);
    rst     <= 1'b0;
    lvr_rst <= 1'b0;
    src     <= '0;
    fl = rexp(fl, pp, ww, lv);
    wpulse(1'b0, c);
    chk({pm.cpu_clk_en, pm.fetch_addr}, 32'h10100);
  endtask : do_rst

  task automatic enter(input logic [7:0] op);
    if (op == rcpd_pkg::OP_STOP)
      wr(rcpd_pkg::OFS_ARM, {24'h0, rcpd_pkg::ARM_PATTERN}, r);
    cpu_u.exec(op, to);
    if (to) hang();
    repeat (3) @(posedge clk);
    #1;
  endtask : enter

  // ==========================================================================
  // Main sequence
  initial
  begin
    void'($urandom(88));
    repeat (8) @(posedge clk);
    rst     <= 1'b0;
    lvr_rst <= 1'b0;
    fl = 8'h02;
    wpulse(1'b0, k);
    chk(32'(pm.clk_sel), 32'h0);
    rchk(rcpd_pkg::OFS_FLAGS, 32'h02);
    rchk(rcpd_pkg::OFS_STATUS, 32'h1);
    rchk(rcpd_pkg::OFS_CFG, 32'h1000);
    rd(8'h20, d, r);
    chk({d[29:0], r}, {30'h0, rcpd_pkg::RESP_SLVERR});
    wr(8'h24, 32'h0, r);
    chk(32'(r), 32'(rcpd_pkg::RESP_SLVERR));
    // Lane 1 off: ring bit lands, stabilization field must stay
    wstrb <= 4'h1;
    wr(rcpd_pkg::OFS_CFG, 32'h2301, r);
    rchk(rcpd_pkg::OFS_CFG, 32'h1001);
    wstrb <= 4'hf;
    // Resets from random sources, then random clearing writes
    for (i = 0; i < 10; i++)
    begin
      p = (i == 0) ? 1'b1 : 1'($urandom);
      w = (i == 0) ? 1'b1 : 1'($urandom);
      do_rst(p, w, i == 6);
      rchk(rcpd_pkg::OFS_FLAGS, {24'h0, fl});
      d = (i == 1) ? 32'hff : $urandom;
      wr(rcpd_pkg::OFS_FLAGS, d, r);
      fl = wexp(fl, d);
      rchk(rcpd_pkg::OFS_FLAGS, {24'h0, fl});
    end
    // Stop without arming is ignored
    cpu_u.exec(rcpd_pkg::OP_STOP, to);
    if (to) hang();
    repeat (3) @(posedge clk);
    #1;
    chk(32'(pm.cpu_clk_en), 32'h1);
    for (i = 0; i < 2; i++)
    begin
      wr(rcpd_pkg::OFS_CFG, {16'h0, 8'(2 + 8 * i), 7'h0, 1'(i)}, r);
      wr(rcpd_pkg::OFS_CLKSEL, 32'h18, r);
      enter(rcpd_pkg::OP_STOP);
      chk({pm.cpu_clk_en, pm.periph_clk_en, pm.main_osc_en}, 32'h0);
      chk(32'(pm.ring_osc_en), 32'(i));
      rchk(rcpd_pkg::OFS_STATUS, 32'h4);
      @(posedge clk);
      irq_req <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      chk(32'(pm.periph_clk_en), 32'h0);
      @(posedge clk);
      irq_unm <= 1'b1;
      wpulse(1'b1, n[i]);
      chk({pm.cpu_clk_en, pm.clk_sel}, 32'h7);
      @(posedge clk);
      irq_req <= 1'b0;
      irq_unm <= 1'b0;
      rchk(rcpd_pkg::OFS_ARM, 32'h0);
      rchk(rcpd_pkg::OFS_CFG, {16'h0, 8'(2 + 8 * i), 7'h0, 1'(i)});
    end
    chk(32'(n[1] - n[0]), 32'h8);
    wr(rcpd_pkg::OFS_CLKSEL, 32'h18, r);
    enter(rcpd_pkg::OP_STOP);
    do_rst(1'b0, 1'b0, 1'b0);
    chk(32'(pm.clk_sel), 32'h0);
    rchk(rcpd_pkg::OFS_CFG, 32'h1000);
    rchk(rcpd_pkg::OFS_FLAGS, {24'h0, fl});
    rchk(rcpd_pkg::OFS_ARM, 32'h0);
    for (i = 0; i < 2; i++)
    begin
      wr(rcpd_pkg::OFS_CLKSEL, 32'h10, r);
      enter(rcpd_pkg::OP_IDLE);
      chk({pm.cpu_clk_en, pm.periph_clk_en, pm.main_osc_en, pm.port_dir_hold}, 32'h7);
      @(posedge clk);
      irq_req <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      chk(32'(pm.cpu_clk_en), 32'h0);
      if (i == 0)
      begin
        @(posedge clk);
        irq_unm <= 1'b1;
        wpulse(1'b1, k);
      end
      else
        do_rst(1'b0, 1'b0, 1'b0);
      chk(32'(pm.clk_sel), (i == 0) ? 32'h2 : 32'h0);
      @(posedge clk);
      irq_req <= 1'b0;
      irq_unm <= 1'b0;
    end
    finish_test();
  end
endmodule : reset_cause_and_power_down_tb
`default_nettype wire
